/* File: design/stc_pkg.sv */
// Purpose: shared constants and types for the sysref phase calibration
// Assumes: register port from the serial control core, 10-bit addresses
// Notes: timing counts are in device sample clock cycles
package stc_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 24;
	localparam logic [9:0] OFF_ENABLE = 10'h2B0;
	localparam logic [9:0] OFF_CONFIG = 10'h2B1;
	localparam logic [9:0] OFF_STATUS = 10'h2B2;
	localparam logic [9:0] OFF_DELAY = 10'h2B5;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h05;
	localparam logic [23:0] DELAY_RESET = 24'h000000;
	localparam int ENABLE_BIT = 0;
	localparam int AVG_LSB = 2;
	localparam int ACC_LSB = 0;
	localparam int SEL_W = 2;
	localparam int DONE_BIT = 17;
	localparam int RESULT_W = 17;
	localparam int INV_BIT = 16;
	localparam int COARSE_LSB = 8;
	localparam int FINE_LSB = 0;
	localparam int CODE_W = 8;
	localparam int STEP_FACTOR = 384 * 19;
	localparam int PERIOD_MAX_0 = 128;
	localparam int PERIOD_MAX_1 = 1664;
	localparam int PERIOD_MAX_2 = 7808;
	localparam int PERIOD_MAX_3 = 32384;
	localparam int COARSE_STEPS = 512;
	localparam int FINE_STEPS = 256;
	localparam int IDX_W = 9;
	localparam int WIN_W = 17;
	localparam int BOUND_W = 30;
	localparam int PERIOD_W = 16;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} stc_reg_req_t;

	typedef struct packed {
		logic inv;
		logic [CODE_W-1:0] coarse;
		logic [CODE_W-1:0] fine;
	} stc_delay_t;
endpackage

/* File: design/stc_window_acc.sv */
// Purpose: counts high samples of sysref over one measurement window
// Assumes: sample is already synchronised to clk
// Notes: window is 4 to the power len_log4 cycles, at most 65536
`timescale 1ns/1ns
module stc_window_acc #(
	parameter int CNT_W = 17
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [3:0] len_log4,
	input wire logic sample,
	output logic done,
	output logic [CNT_W-1:0] count
);
	import stc_pkg::*;

	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [CNT_W-1:0] left_q, left_d;
	logic [CNT_W-1:0] acc_q, acc_d;
	logic [CNT_W-1:0] count_q, count_d;

	always_comb begin
		busy_d = busy_q;
		done_d = 1'b0;
		left_d = left_q;
		acc_d = acc_q;
		count_d = count_q;
		if (start) begin
			busy_d = 1'b1;
			left_d = CNT_W'(1) << (2 * len_log4);
			acc_d = '0;
		end else if (busy_q) begin
			acc_d = acc_q + CNT_W'(sample);
			left_d = left_q - CNT_W'(1);
			if (left_q == CNT_W'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				count_d = acc_q + CNT_W'(sample);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			left_q <= '0;
			acc_q <= '0;
			count_q <= '0;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			left_q <= left_d;
			acc_q <= acc_d;
			count_q <= count_d;
		end
	end

	assign done = done_q;
	assign count = count_q;
endmodule

/* File: design/stc_phase_cal.sv */
// Purpose: sysref sampling phase calibration, its registers and delay path
// Assumes: register port from the serial control core, one clk domain
// Notes: clk is the device sample clock; sysref_in is asynchronous
// Function
// RQ1: averaging select bits 3:2 choose 4, 16, 64 or 256 averages.
// RQ2: accumulation select bits 1:0 choose 4, 16, 64 or 256 cycles.
// RQ3: longest sysref period 128, 1664, 7808 or 32384 cycles per code.
// RQ4: source keeps sysref period within the supported maximum, else failure.
// RQ5: calibration ends within 384*19*4^(avg+acc+2) cycles.
// RQ6: status bit 17 reads one only when enabled and calibration completed.
// RQ7: status bits 16:0 show computed delay, valid only with completion bit.
// RQ8: result bit 16 inversion, bits 15:8 coarse, bits 7:0 fine.
// RQ9: configuration resets to 0x05, bits 7:4 reserved.
// RQ10: status is read-only; contents undefined before completion.
// RQ11: manual delay register 24 bits, reset zero, coarse 15:8, fine 7:0.
// RQ12: enable rising from zero to one starts the calibration.
// RQ13: enabled uses automatic delay; disabled uses manual register.
// RQ14: software configures first and avoids running converter calibration.
// RQ15: manual register bit 16 inverts the sampling clock.
// RQ16: on completion the computed delay drives the delay path.
`timescale 1ns/1ns
module stc_phase_cal
	import stc_pkg::*;
#(
	parameter int STEP_FACTOR_P = STEP_FACTOR,
	parameter int PERIOD_MAX_0_P = PERIOD_MAX_0,
	parameter int PERIOD_MAX_1_P = PERIOD_MAX_1,
	parameter int PERIOD_MAX_2_P = PERIOD_MAX_2,
	parameter int PERIOD_MAX_3_P = PERIOD_MAX_3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sysref_in,
	input wire stc_pkg::stc_reg_req_t reg_req,
	output logic [stc_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output stc_pkg::stc_delay_t delay_out,
	output logic cal_busy,
	output logic cal_failed
);
	import stc_pkg::*;

	typedef enum logic [2:0] {
		STC_IDLE,
		STC_LAUNCH,
		STC_MEASURE,
		STC_DONE,
		STC_FAIL
	} stc_state_t;

	function automatic logic [PERIOD_W-1:0] period_max(
		input logic [SEL_W-1:0] acc_sel
	);
		logic [PERIOD_W-1:0] r;
		r = PERIOD_W'(PERIOD_MAX_0_P);
		unique case (acc_sel)
			2'h0: r = PERIOD_W'(PERIOD_MAX_0_P);
			2'h1: r = PERIOD_W'(PERIOD_MAX_1_P);
			2'h2: r = PERIOD_W'(PERIOD_MAX_2_P);
			2'h3: r = PERIOD_W'(PERIOD_MAX_3_P);
		endcase
		return r;
	endfunction

	function automatic logic [WIN_W-1:0] abs_diff(
		input logic [WIN_W-1:0] a,
		input logic [WIN_W-1:0] b
	);
		return (a > b) ? (a - b) : (b - a);
	endfunction

	// register state
	logic en_q, en_d;
	logic en_prev_q, en_prev_d;
	logic [7:0] cfg_q, cfg_d;
	logic [DATA_W-1:0] manual_q, manual_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;

	// sysref synchroniser
	logic sync1_q, sync2_q, sync3_q;

	// calibration state
	stc_state_t state_q, state_d;
	logic fine_phase_q, fine_phase_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic [WIN_W-1:0] prev_q, prev_d;
	logic [WIN_W-1:0] best_score_q, best_score_d;
	logic [IDX_W-1:0] best_idx_q, best_idx_d;
	logic [RESULT_W-1:0] coarse_pick_q, coarse_pick_d;
	logic [RESULT_W-1:0] result_q, result_d;
	logic done_q, done_d;
	logic fail_q, fail_d;
	logic [BOUND_W-1:0] elapsed_q, elapsed_d;
	logic [PERIOD_W-1:0] since_edge_q, since_edge_d;
	stc_delay_t delay_q, delay_d;

	logic [SEL_W-1:0] avg_sel, acc_sel;
	logic [3:0] win_log4;
	logic [BOUND_W-1:0] bound;
	logic acc_start, acc_done;
	logic [WIN_W-1:0] acc_count;
	logic sysref_rise;
	logic start_cal;
	logic [RESULT_W-1:0] cand;

	assign avg_sel = cfg_q[AVG_LSB +: SEL_W];
	assign acc_sel = cfg_q[ACC_LSB +: SEL_W];
	// averages times accumulation cycles: 4^(avg+1) * 4^(acc+1)
	assign win_log4 = 4'(avg_sel) + 4'(acc_sel) + 4'h2; // see RQ1 see RQ2
	assign bound = BOUND_W'(STEP_FACTOR_P) << (2 * win_log4); // see RQ5
	assign sysref_rise = sync2_q & ~sync3_q;
	assign start_cal = en_q & ~en_prev_q; // see RQ12
	assign acc_start = (state_q == STC_LAUNCH);

	stc_window_acc #(
		.CNT_W(WIN_W)
	) u_acc (
		.clk(clk),
		.rst(rst),
		.start(acc_start),
		.len_log4(win_log4),
		.sample(sync2_q),
		.done(acc_done),
		.count(acc_count)
	);

	// candidate under test: inversion and coarse first, then fine
	always_comb begin
		if (fine_phase_q) begin
			cand = {coarse_pick_q[RESULT_W-1:COARSE_LSB],
				idx_q[CODE_W-1:0]};
		end else begin
			cand = {idx_q, {CODE_W{1'b0}}};
		end
	end

	// register port
	always_comb begin
		en_d = en_q;
		cfg_d = cfg_q;
		manual_d = manual_q;
		rdata_d = rdata_q;
		rvalid_d = reg_req.rd;
		en_prev_d = en_q;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				OFF_ENABLE: en_d = reg_req.wdata[ENABLE_BIT];
				OFF_CONFIG: cfg_d = reg_req.wdata[7:0]; // see RQ9
				OFF_DELAY: manual_d = reg_req.wdata; // see RQ11
				default: ; // status is read-only, see RQ10
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				OFF_ENABLE: rdata_d = DATA_W'(en_q);
				OFF_CONFIG: rdata_d = DATA_W'(cfg_q);
				OFF_STATUS: begin
					rdata_d = '0;
					rdata_d[DONE_BIT] = en_q & done_q; // see RQ6
					rdata_d[RESULT_W-1:0] = result_q; // see RQ7
				end
				OFF_DELAY: rdata_d = manual_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= ENABLE_RESET[ENABLE_BIT];
			en_prev_q <= 1'b0;
			cfg_q <= CONFIG_RESET; // see RQ9
			manual_q <= DELAY_RESET; // see RQ11
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else begin
			en_q <= en_d;
			en_prev_q <= en_prev_d;
			cfg_q <= cfg_d;
			manual_q <= manual_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= sysref_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// calibration sequence
	always_comb begin
		state_d = state_q;
		fine_phase_d = fine_phase_q;
		idx_d = idx_q;
		prev_d = prev_q;
		best_score_d = best_score_q;
		best_idx_d = best_idx_q;
		coarse_pick_d = coarse_pick_q;
		result_d = result_q;
		done_d = done_q;
		fail_d = fail_q;
		elapsed_d = elapsed_q;
		since_edge_d = since_edge_q;
		unique case (state_q)
			STC_IDLE, STC_DONE, STC_FAIL: ;
			STC_LAUNCH: begin
				elapsed_d = elapsed_q + BOUND_W'(1);
				state_d = STC_MEASURE;
			end
			STC_MEASURE: begin
				elapsed_d = elapsed_q + BOUND_W'(1);
				if (sysref_rise) begin
					since_edge_d = '0;
				end else begin
					since_edge_d = since_edge_q + PERIOD_W'(1);
				end
				if (acc_done) begin
					prev_d = acc_count;
					if (idx_q != '0 &&
						abs_diff(acc_count, prev_q) > best_score_q) begin
						best_score_d = abs_diff(acc_count, prev_q);
						best_idx_d = idx_q;
					end
					state_d = STC_LAUNCH;
					idx_d = idx_q + IDX_W'(1);
					if (!fine_phase_q &&
						idx_q == IDX_W'(COARSE_STEPS - 1)) begin
						fine_phase_d = 1'b1;
						idx_d = '0;
						best_score_d = '0;
						coarse_pick_d = {best_idx_d, {CODE_W{1'b0}}};
						best_idx_d = '0;
					end else if (fine_phase_q &&
						idx_q == IDX_W'(FINE_STEPS - 1)) begin
						state_d = STC_DONE;
						result_d = {coarse_pick_q[RESULT_W-1:COARSE_LSB],
							best_idx_d[CODE_W-1:0]}; // see RQ8
						done_d = 1'b1;
					end
				end
				// sysref too slow or time bound spent, see RQ3 see RQ4
				if (since_edge_q >= period_max(acc_sel) ||
					elapsed_q >= bound - BOUND_W'(1)) begin // see RQ5
					state_d = STC_FAIL;
					fail_d = 1'b1;
					done_d = 1'b0;
				end
			end
			default: state_d = STC_IDLE;
		endcase
		if (start_cal) begin // see RQ12
			state_d = STC_LAUNCH;
			fine_phase_d = 1'b0;
			idx_d = '0;
			prev_d = '0;
			best_score_d = '0;
			best_idx_d = '0;
			done_d = 1'b0;
			fail_d = 1'b0;
			elapsed_d = '0;
			since_edge_d = '0;
		end else if (!en_q) begin
			state_d = STC_IDLE;
			done_d = 1'b0; // see RQ6
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= STC_IDLE;
			fine_phase_q <= 1'b0;
			idx_q <= '0;
			prev_q <= '0;
			best_score_q <= '0;
			best_idx_q <= '0;
			coarse_pick_q <= '0;
			result_q <= '0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			elapsed_q <= '0;
			since_edge_q <= '0;
		end else begin
			state_q <= state_d;
			fine_phase_q <= fine_phase_d;
			idx_q <= idx_d;
			prev_q <= prev_d;
			best_score_q <= best_score_d;
			best_idx_q <= best_idx_d;
			coarse_pick_q <= coarse_pick_d;
			result_q <= result_d;
			done_q <= done_d;
			fail_q <= fail_d;
			elapsed_q <= elapsed_d;
			since_edge_q <= since_edge_d;
		end
	end

	// delay path selection
	always_comb begin
		if (!en_q) begin
			delay_d.inv = manual_q[INV_BIT]; // see RQ13 see RQ15
			delay_d.coarse = manual_q[COARSE_LSB +: CODE_W];
			delay_d.fine = manual_q[FINE_LSB +: CODE_W];
		end else if (done_q) begin
			delay_d.inv = result_q[INV_BIT]; // see RQ16
			delay_d.coarse = result_q[COARSE_LSB +: CODE_W];
			delay_d.fine = result_q[FINE_LSB +: CODE_W];
		end else if (state_q == STC_LAUNCH || state_q == STC_MEASURE) begin
			delay_d.inv = cand[INV_BIT]; // see RQ13
			delay_d.coarse = cand[COARSE_LSB +: CODE_W];
			delay_d.fine = cand[FINE_LSB +: CODE_W];
		end else begin
			delay_d = delay_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			delay_q <= '0;
		end else begin
			delay_q <= delay_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign delay_out = delay_q;
	assign cal_busy = (state_q == STC_LAUNCH) || (state_q == STC_MEASURE);
	assign cal_failed = fail_q;
endmodule

/* File: testbench/stc_phase_cal_assertions.sv */
// Purpose: checker for the phase calibration ports
// Assumes: one clock domain, shadow copies of written registers
// Notes: bound into stc_phase_cal
`timescale 1ns/1ns
module stc_phase_cal_chk
	import stc_pkg::*;
#(
	parameter int STEP_FACTOR_P = STEP_FACTOR
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sysref_in,
	input wire stc_pkg::stc_reg_req_t reg_req,
	input wire logic [stc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire stc_pkg::stc_delay_t delay_out,
	input wire logic cal_busy,
	input wire logic cal_failed
);
	logic [7:0] cfg_q, cfg_d;
	logic [23:0] man_q, man_d;
	logic en_q, en_d;
	logic [9:0] ra_q, ra_d;
	logic [1:0] qt_q, qt_d;
	logic [31:0] bc_q, bc_d;
	logic [31:0] bound;
	logic wr_en, wr_dl;
	always_comb begin
		wr_en = reg_req.wr && reg_req.addr == OFF_ENABLE;
		wr_dl = reg_req.wr && reg_req.addr == OFF_DELAY;
		cfg_d = cfg_q;
		if (reg_req.wr && reg_req.addr == OFF_CONFIG) begin
			cfg_d = reg_req.wdata[7:0];
		end
		man_d = wr_dl ? reg_req.wdata : man_q;
		en_d = wr_en ? reg_req.wdata[0] : en_q;
		ra_d = reg_req.rd ? reg_req.addr : ra_q;
		// cycles since the last enable or manual write, saturating at 3
		qt_d = (wr_en || wr_dl) ? 2'h0 : (qt_q == 2'h3 ? qt_q : qt_q + 2'h1);
		bc_d = cal_busy ? bc_q + 32'h1 : 32'h0;
		bound = 32'(STEP_FACTOR_P) << (4 + 2 * (cfg_q[3:2] + cfg_q[1:0]));
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= CONFIG_RESET;
			man_q <= DELAY_RESET;
			en_q <= 1'b0;
			ra_q <= 10'h000;
			qt_q <= 2'h0;
			bc_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			man_q <= man_d;
			en_q <= en_d;
			ra_q <= ra_d;
			qt_q <= qt_d;
			bc_q <= bc_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read not answered");
	cfg_read_a: assert property (reg_rvalid && ra_q == OFF_CONFIG
		|-> reg_rdata == {16'h0000, cfg_q}) else $error("config readback");
	tad_read_a: assert property (reg_rvalid && ra_q == OFF_DELAY
		|-> reg_rdata == man_q) else $error("manual readback");
	status_bits_a: assert property (reg_rvalid && ra_q == OFF_STATUS
		|-> reg_rdata[23:18] == 6'h00 && (!reg_rdata[17] || en_q))
		else $error("status bits");
	result_path_a: assert property (reg_rvalid && ra_q == OFF_STATUS
		&& reg_rdata[17] |-> delay_out == reg_rdata[16:0])
		else $error("result not applied");
	manual_path_a: assert property (!en_q && qt_q == 2'h3
		|-> delay_out == man_q[16:0]) else $error("manual not applied");
	idle_off_a: assert property (!en_q && qt_q == 2'h3 |-> !cal_busy)
		else $error("busy while disabled");
	start_rise_a: assert property (wr_en && reg_req.wdata[0] && !en_q
		|-> ##[1:3] cal_busy) else $error("no start");
	cal_bound_a: assert property (bc_q <= bound)
		else $error("calibration too long");
	cover property (reg_rvalid && ra_q == OFF_STATUS && reg_rdata[17]);
	cover property ($rose(cal_failed));
	cover property ($fell(cal_busy));
endmodule

bind stc_phase_cal stc_phase_cal_chk #(.STEP_FACTOR_P(STEP_FACTOR_P)) u_chk (
	.clk(clk),
	.rst(rst),
	.sysref_in(sysref_in),
	.reg_req(reg_req),
	.reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid),
	.delay_out(delay_out),
	.cal_busy(cal_busy),
	.cal_failed(cal_failed)
);

/* File: testbench/stc_sysref_src.sv */
// Purpose: periodic sysref source facing the calibration block
// Assumes: period counted in device clock cycles
// Notes: run low stops the source with sysref held low
`timescale 1ns/1ns
module stc_sysref_src #(
	parameter int PER = 64
) (
	input wire logic clk,
	input wire logic run,
	output logic sysref
);
	int cnt = 0;
	initial sysref = 1'b0;
	always @(posedge clk) begin
		cnt <= (cnt + 1) % PER;
		// period kept under the longest supported
		sysref <= #2 run && cnt < PER / 2;
	end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the phase calibration block
// Assumes: config 0x00 keeps one calibration near 14k cycles
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/1ns
module tb_top;
	import stc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b1;
	logic sysref;
	stc_reg_req_t req = '0;
	logic [23:0] rdata;
	logic rvalid;
	stc_delay_t dly;
	logic busy;
	logic failed;
	int err_total = 0;
	int n_checks = 0;
	logic [23:0] v;
	always #25 clk = ~clk;
	stc_sysref_src u_stc_sysref_src (
		.clk(clk),
		.run(run),
		.sysref(sysref)
	);
	stc_phase_cal u_stc_phase_cal (
		.clk(clk),
		.rst(rst),
		.sysref_in(sysref),
		.reg_req(req),
		.reg_rdata(rdata),
		.reg_rvalid(rvalid),
		.delay_out(dly),
		.cal_busy(busy),
		.cal_failed(failed)
	);
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [9:0] a, input logic [23:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [9:0] a, output logic [23:0] d);
		req.rd = 1'b1;
		req.addr = a;
		tick(1);
		req.rd = 1'b0;
		chk("rvalid", 24'h1, 24'(rvalid));
		d = rdata;
		tick(1);
	endtask
	task automatic wait_idle(input int lim, output int n);
		n = 0;
		while (busy !== 1'b0 && n < lim) begin
			tick(1);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			$display("Error busy expected 0 seen timeout");
			tally_and_finish();
		end
	endtask
	task automatic t_reset();
		rd(OFF_CONFIG, v);
		chk("config", 24'h000005, v);
		rd(OFF_DELAY, v);
		chk("manual", 24'h000000, v);
		rd(OFF_STATUS, v);
		chk("done", 24'h0, 24'(v[17]));
		chk("delay_out", 24'h0, 24'(dly));
	endtask
	task automatic t_regs();
		wr(OFF_CONFIG, 24'h0000F0);
		rd(OFF_CONFIG, v);
		chk("config", 24'h0000F0, v);
		wr(OFF_CONFIG, 24'h000000);
		wr(OFF_DELAY, 24'h01A5C3);
		rd(OFF_DELAY, v);
		chk("manual", 24'h01A5C3, v);
		chk("delay_out", 24'h01A5C3, 24'(dly));
		wr(OFF_STATUS, 24'hFFFFFF);
		rd(OFF_STATUS, v);
		chk("status", 24'h0, {v[23:17], 17'h0});
		rd(10'h2B3, v);
		chk("unmapped", 24'h0, v);
	endtask
	task automatic t_cal();
		int n;
		wr(OFF_ENABLE, 24'h000001);
		chk("busy", 24'h1, 24'(busy));
		wait_idle(20000, n);
		chk("in_time", 24'h1, 24'(n < 7296 * 16));
		chk("failed", 24'h0, 24'(failed));
		rd(OFF_STATUS, v);
		chk("done", 24'h1, 24'(v[17]));
		chk("applied", 24'(v[16:0]), 24'(dly));
		chk("inv", 24'(v[16]), 24'(dly.inv));
		chk("coarse", 24'(v[15:8]), 24'(dly.coarse));
		chk("fine", 24'(v[7:0]), 24'(dly.fine));
		wr(OFF_DELAY, 24'h005A3C);
		chk("ignored", 24'(v[16:0]), 24'(dly));
		wr(OFF_ENABLE, 24'h0);
		rd(OFF_STATUS, v);
		chk("done", 24'h0, 24'(v[17]));
		chk("delay_out", 24'h005A3C, 24'(dly));
	endtask
	task automatic t_fail();
		int n;
		run = 1'b0;
		wr(OFF_ENABLE, 24'h000001);
		wait_idle(2000, n);
		chk("failed", 24'h1, 24'(failed));
		rd(OFF_STATUS, v);
		chk("done", 24'h0, 24'(v[17]));
		wr(OFF_ENABLE, 24'h0);
		run = 1'b1;
	endtask
	task automatic t_fail_long();
		int n;
		wr(OFF_CONFIG, 24'h000001);
		run = 1'b0;
		wr(OFF_ENABLE, 24'h000001);
		tick(1000);
		chk("busy", 24'h1, 24'(busy));
		chk("failed", 24'h0, 24'(failed));
		wait_idle(2000, n);
		chk("failed", 24'h1, 24'(failed));
		wr(OFF_ENABLE, 24'h0);
		wr(OFF_CONFIG, 24'h000000);
		run = 1'b1;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#2;
		rst = 1'b0;
		tick(1);
		t_reset();
		t_regs();
		t_cal();
		t_fail();
		t_fail_long();
		tally_and_finish();
	end
endmodule
